// ---- verilog/acb_timebase.v ----
// counter_array timebase: 16-bit free-running counter with snapshot read
// assumes an Avalon-MM master with byte addresses; all inputs synchronous
// except ext_count_input_i and ext_osc_i, which are synchronised inside
`timescale 1ns/1ps
`include "acb_consts.vh"
module acb_timebase #(
  parameter DIV_SLOW = `ACB_DIV_SLOW,
  parameter DIV_FAST = `ACB_DIV_FAST,
  parameter DIV_OSC = `ACB_DIV_OSC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // count sources and system state
  input wire timer0_ovf_i,
  input wire ext_count_input_i,
  input wire ext_osc_i,
  input wire cpu_idle_i,
  // outputs to the capture modules and interrupt controller
  output wire [15:0] count_o,
  output wire overflow_pulse_o,
  output wire irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  reg [15:0] count_ff;
  reg [15:0] nxt_count;
  reg [7:0] snapshot_ff;
  reg [7:0] nxt_snapshot;
  reg [2:0] timebase_select_ff;
  reg [2:0] nxt_timebase_select;
  reg idle_suspend_ff;
  reg nxt_idle_suspend;
  reg overflow_flag_ff;
  reg nxt_overflow_flag;
  reg overflow_irq_enable_ff;
  reg nxt_overflow_irq_enable;
  reg ovf_pulse_ff;
  reg irq_ff;
  reg waitreq_ff;
  reg nxt_waitreq;
  reg [31:0] readdata_ff;
  reg [31:0] nxt_readdata;
  reg [31:0] rd_mux;
  // mode reset image, split into its fields at reset
  localparam [7:0] RST_MODE = `ACB_RST_MODE;

  wire tick;
  wire run;
  wire cnt_en;
  wire wrap;
  wire req;
  wire accept;
  wire done;
  wire wr_done;
  wire rd_accept;
  wire lane0;
  wire [7:0] wbyte;
  wire sel_cnt_lo;
  wire sel_cnt_hi;
  wire sel_mode;
  wire sel_status;
  wire sel_mask;

  ////////////////////////////////////////////////////////////////////////
  // timebase selection and prescaling
  acb_tick_gen #(
    .DIV_SLOW(DIV_SLOW),
    .DIV_FAST(DIV_FAST),
    .DIV_OSC(DIV_OSC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .timebase_select_i(timebase_select_ff),
    .timer0_ovf_i(timer0_ovf_i),
    .ext_count_input_i(ext_count_input_i),
    .ext_osc_i(ext_osc_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshake
  // one wait state: the request is seen with waitrequest high, then
  // waitrequest drops for exactly one cycle, at whose end it completes
  assign req = avs_read_i | avs_write_i;
  assign accept = req & waitreq_ff;
  assign done = req & ~waitreq_ff;
  assign wr_done = done & avs_write_i;
  assign rd_accept = avs_read_i & waitreq_ff;
  assign lane0 = avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  // address decode
  assign sel_cnt_lo = (avs_address_i == `ACB_OFF_CNT_LO);
  assign sel_cnt_hi = (avs_address_i == `ACB_OFF_CNT_HI);
  assign sel_mode = (avs_address_i == `ACB_OFF_MODE);
  assign sel_status = (avs_address_i == `ACB_OFF_STATUS);
  assign sel_mask = (avs_address_i == `ACB_OFF_MASK);

  always @* begin
    nxt_waitreq = 1'b1;
    if (accept) begin
      nxt_waitreq = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data path
  // the high-byte word always returns the snapshot, so a low-then-high
  // pair is coherent even if the counter carries in between
  always @* begin
    rd_mux = 32'h0000_0000;
    if (sel_cnt_lo) begin
      rd_mux[7:0] = count_ff[7:0];
    end else if (sel_cnt_hi) begin
      rd_mux[7:0] = snapshot_ff;
    end else if (sel_mode) begin
      rd_mux[`ACB_MODE_SEL_MSB:`ACB_MODE_SEL_LSB] = timebase_select_ff;
      rd_mux[`ACB_MODE_IDLE_BIT] = idle_suspend_ff;
    end else if (sel_status) begin
      rd_mux[`ACB_STAT_OVF_BIT] = overflow_flag_ff;
    end else if (sel_mask) begin
      rd_mux[`ACB_STAT_OVF_BIT] = overflow_irq_enable_ff;
    end
  end

  always @* begin
    nxt_readdata = readdata_ff;
    if (rd_accept) begin
      nxt_readdata = rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // snapshot of the high byte
  // captured together with the low byte so both come from one count value
  always @* begin
    nxt_snapshot = snapshot_ff;
    if (rd_accept && sel_cnt_lo) begin
      nxt_snapshot = count_ff[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode and mask registers
  always @* begin
    nxt_timebase_select = timebase_select_ff;
    nxt_idle_suspend = idle_suspend_ff;
    nxt_overflow_irq_enable = overflow_irq_enable_ff;
    if (wr_done && lane0 && sel_mode) begin
      nxt_timebase_select = wbyte[`ACB_MODE_SEL_MSB:`ACB_MODE_SEL_LSB];
      nxt_idle_suspend = wbyte[`ACB_MODE_IDLE_BIT];
    end
    if (wr_done && lane0 && sel_mask) begin
      nxt_overflow_irq_enable = wbyte[`ACB_STAT_OVF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter
  // idle gating only applies when software asked for it
  assign run = ~(idle_suspend_ff & cpu_idle_i);
  assign cnt_en = tick & run;
  assign wrap = cnt_en && (count_ff == `ACB_COUNT_MAX);

  // reads never touch the count; a software write to a byte wins over
  // the increment of that cycle, other byte still advances normally
  always @* begin
    nxt_count = count_ff;
    if (cnt_en) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (wr_done && lane0 && sel_cnt_lo) begin
      nxt_count[7:0] = wbyte;
    end
    if (wr_done && lane0 && sel_cnt_hi) begin
      nxt_count[15:8] = wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow flag
  // write one clears; a wrap in the same cycle wins so no event is lost
  always @* begin
    nxt_overflow_flag = overflow_flag_ff;
    if (wr_done && lane0 && sel_status && wbyte[`ACB_STAT_OVF_BIT]) begin
      nxt_overflow_flag = 1'b0;
    end
    if (wrap) begin
      nxt_overflow_flag = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= `ACB_RST_COUNT;
      snapshot_ff <= 8'h00;
      timebase_select_ff <= RST_MODE[`ACB_MODE_SEL_MSB:`ACB_MODE_SEL_LSB];
      idle_suspend_ff <= RST_MODE[`ACB_MODE_IDLE_BIT];
      overflow_flag_ff <= 1'b0;
      overflow_irq_enable_ff <= `ACB_RST_MASK;
      ovf_pulse_ff <= 1'b0;
      irq_ff <= 1'b0;
      waitreq_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else begin
      count_ff <= nxt_count;
      snapshot_ff <= nxt_snapshot;
      timebase_select_ff <= nxt_timebase_select;
      idle_suspend_ff <= nxt_idle_suspend;
      overflow_flag_ff <= nxt_overflow_flag;
      overflow_irq_enable_ff <= nxt_overflow_irq_enable;
      ovf_pulse_ff <= wrap;
      // request only while enabled; flag itself is unaffected
      irq_ff <= nxt_overflow_flag & nxt_overflow_irq_enable;
      waitreq_ff <= nxt_waitreq;
      readdata_ff <= nxt_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata_o = readdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign count_o = count_ff;
  assign overflow_pulse_o = ovf_pulse_ff;
  assign irq_o = irq_ff;

endmodule

// ---- verilog/acb_consts.vh ----
// constants for the counter_array timebase: register map, fields, codes
// assumes inclusion by bare name from each design file that needs them
`ifndef ACB_CONSTS_VH
`define ACB_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets (one aligned 32-bit word each)
`define ACB_OFF_CNT_LO 5'h00
`define ACB_OFF_CNT_HI 5'h04
`define ACB_OFF_MODE 5'h08
`define ACB_OFF_STATUS 5'h0c
`define ACB_OFF_MASK 5'h10

////////////////////////////////////////////////////////////////////////
// array_mode_reg fields
`define ACB_MODE_SEL_LSB 1
`define ACB_MODE_SEL_MSB 3
`define ACB_MODE_IDLE_BIT 7
// status and mask fields
`define ACB_STAT_OVF_BIT 0

////////////////////////////////////////////////////////////////////////
// reset values and counter maximum
`define ACB_RST_MODE 8'h00
`define ACB_RST_MASK 1'b0
`define ACB_RST_COUNT 16'h0000
`define ACB_COUNT_MAX 16'hffff

////////////////////////////////////////////////////////////////////////
// timebase_select codes
`define ACB_SEL_DIV12 3'h0
`define ACB_SEL_DIV4 3'h1
`define ACB_SEL_T0OVF 3'h2
`define ACB_SEL_EXTIN 3'h3
`define ACB_SEL_SYSTEM_CLOCK 3'h4
`define ACB_SEL_OSC8 3'h5

////////////////////////////////////////////////////////////////////////
// divide ratios
`define ACB_DIV_SLOW 12
`define ACB_DIV_FAST 4
`define ACB_DIV_OSC 8

`endif

// ---- verilog/acb_sync_edge.v ----
// two-flop synchroniser with edge detection for one slow input
// assumes the input changes no faster than a few system clocks
`timescale 1ns/1ps
module acb_sync_edge (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // raw input
  input wire async_i,
  // synchronised edge pulses
  output wire rise_o,
  output wire fall_o
);

  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  // first stage feeds only the second
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;

endmodule

// ---- verilog/acb_tick_gen.v ----
// count-enable generator: picks one timebase from the select code
// assumes timer0_ovf_i is a one-cycle pulse in the system clock domain
`timescale 1ns/1ps
`include "acb_consts.vh"
module acb_tick_gen #(
  parameter DIV_SLOW = `ACB_DIV_SLOW,
  parameter DIV_FAST = `ACB_DIV_FAST,
  parameter DIV_OSC = `ACB_DIV_OSC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // selection
  input wire [2:0] timebase_select_i,
  // sources
  input wire timer0_ovf_i,
  input wire ext_count_input_i,
  input wire ext_osc_i,
  // one-cycle count enable
  output wire tick_o
);

  reg [3:0] slow_cnt_ff;
  reg [3:0] fast_cnt_ff;
  reg [3:0] osc_cnt_ff;
  reg osc_tick_ff;
  reg tick;
  wire ext_fall;
  wire osc_rise;
  wire slow_wrap;
  wire fast_wrap;
  wire osc_wrap;

  ////////////////////////////////////////////////////////////////////////
  // external sources pass a synchroniser before use
  acb_sync_edge u_ext_in (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_count_input_i),
    .rise_o(),
    .fall_o(ext_fall)
  );

  acb_sync_edge u_osc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_osc_i),
    .rise_o(osc_rise),
    .fall_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // free-running prescalers
  assign slow_wrap = (slow_cnt_ff == DIV_SLOW[3:0] - 4'h1);
  assign fast_wrap = (fast_cnt_ff == DIV_FAST[3:0] - 4'h1);
  assign osc_wrap = osc_rise && (osc_cnt_ff == DIV_OSC[3:0] - 4'h1);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_cnt_ff <= 4'h0;
      fast_cnt_ff <= 4'h0;
      osc_cnt_ff <= 4'h0;
      osc_tick_ff <= 1'b0;
    end else begin
      slow_cnt_ff <= slow_wrap ? 4'h0 : slow_cnt_ff + 4'h1;
      fast_cnt_ff <= fast_wrap ? 4'h0 : fast_cnt_ff + 4'h1;
      if (osc_rise) begin
        osc_cnt_ff <= osc_wrap ? 4'h0 : osc_cnt_ff + 4'h1;
      end
      osc_tick_ff <= osc_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source mux
  always @* begin
    case (timebase_select_i)
      `ACB_SEL_DIV12: tick = slow_wrap;
      `ACB_SEL_DIV4: tick = fast_wrap;
      `ACB_SEL_T0OVF: tick = timer0_ovf_i;
      `ACB_SEL_EXTIN: tick = ext_fall;
      `ACB_SEL_SYSTEM_CLOCK: tick = 1'b1;
      `ACB_SEL_OSC8: tick = osc_tick_ff;
      default: tick = 1'b0;
    endcase
  end

  assign tick_o = tick;

endmodule

// ---- testbench/acb_timebase_properties.sv ----
// port checker for the counter_array timebase
// assumes it is bound onto acb_timebase; one clock domain
`timescale 1ns/1ps
module acb_timebase_properties (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // register bus
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // counter side
  input wire [15:0] count_o,
  input wire overflow_pulse_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_done = avs_write_i && !avs_waitrequest_o;
  ////////////////////////////////////////////////////////////////////////
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_one_wait: assert property (s_req |=> s_ack)
    else $error("bus answer not after one wait state");
  a_idle_wait: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("waitrequest dropped with no request");
  a_rd_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h0) else $error("read data upper bits set");
  a_unmapped_rd: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 5'h10
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////////////////
  a_count_step: assert property (count_o != $past(count_o)
    |-> count_o == $past(count_o) + 16'h1 || $past(wr_done)) else $error("count jumped");
  a_wrap_flag: assert property ($past(count_o) == 16'hffff && count_o == 16'h0
    |-> overflow_pulse_o) else $error("wrap without overflow pulse");
  a_pulse_cause: assert property (overflow_pulse_o
    |-> count_o == 16'h0 && $past(count_o) == 16'hffff) else $error("pulse without wrap");
  a_irq_cause: assert property ($rose(irq_o)
    |-> overflow_pulse_o || $past(wr_done) || $past(wr_done, 2)) else $error("irq rose alone");
  a_irq_sticky: assert property ($fell(irq_o)
    |-> $past(wr_done) || $past(wr_done, 2)) else $error("irq fell without a write");
endmodule

// ---- testbench/acb_timebase_tb.sv ----
// self-checking bench for the counter_array timebase
// assumes the checker file is compiled first; bus has one wait state
`timescale 1ns/1ps
module acb_timebase_tb;
  reg clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  reg [4:0] avs_address_i = 0;
  reg [31:0] avs_writedata_i = 0;
  reg [3:0] avs_byteenable_i = 4'h1;
  reg timer0_ovf_i = 0, ext_count_input_i = 1, ext_osc_i = 0, cpu_idle_i = 0, stim = 0;
  reg [7:0] cyc = 0;
  reg [31:0] q;
  reg [15:0] d;
  reg [15:0] base;
  reg [7:0] pulses = 0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, overflow_pulse_o, irq_o;
  wire [15:0] count_o;
  integer errors = 0, num_checks = 0, i;
  reg [2:0] sl [0:7] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7, 3'h2, 3'h3, 3'h5};
  reg [15:0] ex [0:7] = '{16'h4, 16'hc, 16'h30, 16'h0, 16'h0, 16'h6, 16'h6, 16'h3};
  acb_timebase u_acb_timebase (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .timer0_ovf_i(timer0_ovf_i), .ext_count_input_i(ext_count_input_i),
    .ext_osc_i(ext_osc_i), .cpu_idle_i(cpu_idle_i), .count_o(count_o),
    .overflow_pulse_o(overflow_pulse_o), .irq_o(irq_o));
  initial forever #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  // sources: timer0 every 8, ext input falls every 8 (system_clock/4 limit), osc toggles every clock (rises every 2)
  always @(posedge clk_i) begin
    cyc <= stim ? cyc + 8'h1 : 8'h0;
    timer0_ovf_i <= stim && cyc[2:0] == 3'h7;
    if (stim && cyc[1:0] == 2'h3) ext_count_input_i <= ~ext_count_input_i;
    if (stim) ext_osc_i <= ~ext_osc_i;
    if (overflow_pulse_o) pulses <= pulses + 8'h1;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // holds the request until waitrequest is seen low, then one idle edge
  task bus(input [4:0] a, input w, input [7:0] dt);
    begin
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'h0, dt};
      // no local limit: only the watchdog may end a wait
      do begin
        @(posedge clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task span(input integer n);
    reg [15:0] c0;
    begin
      c0 = count_o;
      repeat (n) @(posedge clk_i);
      d = count_o - c0;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #(25 * 20000);
    errors = errors + 1;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(5'h08, 0, 0); chk(q, 32'h0);
    bus(5'h0c, 0, 0); chk(q, 32'h0);
    bus(5'h10, 0, 0); chk(q, 32'h0);
    bus(5'h14, 1, 8'hff);
    bus(5'h14, 0, 0); chk(q, 32'h0);
    $display("reset and map test done");
    for (i = 0; i < 8; i = i + 1) begin
      bus(5'h08, 1, {4'h0, sl[i], 1'b0});
      stim <= 1'b1;
      span(48);
      stim <= 1'b0;
      // event sources: let the synchroniser and divider pipelines drain
      if (i > 4) begin
        base = count_o - d;
        repeat (8) @(posedge clk_i);
        d = count_o - base;
      end
      chk(d, ex[i]);
    end
    $display("timebase test done");
    // snapshot: high byte frozen by the low-byte read while live count moves on
    bus(5'h08, 1, 8'h08);
    bus(5'h00, 1, 8'hf0);
    bus(5'h04, 1, 8'h12);
    bus(5'h00, 0, 0); chk(q, 32'hf4);
    repeat (20) @(posedge clk_i);
    bus(5'h04, 0, 0); chk(q, 32'h12);
    chk(count_o[15:8], 8'h13);
    $display("snapshot test done");
    bus(5'h04, 1, 8'hff);
    bus(5'h00, 1, 8'hf0);
    repeat (30) @(posedge clk_i);
    bus(5'h0c, 0, 0); chk(q, 32'h1);
    chk(pulses, 8'h1);
    chk(irq_o, 1'b0);
    avs_byteenable_i <= 4'h0;
    bus(5'h10, 1, 8'h01); chk(irq_o, 1'b0);
    avs_byteenable_i <= 4'h1;
    bus(5'h10, 1, 8'h01); chk(irq_o, 1'b1);
    repeat (10) @(posedge clk_i);
    bus(5'h0c, 0, 0); chk(q, 32'h1);
    bus(5'h0c, 1, 8'h01); @(posedge clk_i); chk(irq_o, 1'b0);
    bus(5'h0c, 0, 0); chk(q, 32'h0);
    $display("overflow test done");
    bus(5'h08, 1, 8'h88);
    cpu_idle_i <= 1'b1;
    @(posedge clk_i);
    span(16); chk(d, 16'h0);
    cpu_idle_i <= 1'b0;
    @(posedge clk_i);
    span(16); chk(d, 16'h10);
    bus(5'h08, 1, 8'h08);
    cpu_idle_i <= 1'b1;
    span(16); chk(d, 16'h10);
    $display("idle test done");
    test_done;
  end
endmodule

bind acb_timebase acb_timebase_properties u_acb_timebase_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .count_o(count_o),
  .overflow_pulse_o(overflow_pulse_o), .irq_o(irq_o));
